// [auto_sleep_pkg.sv]
// Constants for the auto wake/sleep sample-rate controller.
package auto_sleep_pkg;
  // Register offsets.
  localparam logic [7:0] ADDR_TIMEOUT = 8'h29;
  localparam logic [7:0] ADDR_CTRL1 = 8'h2A;
  localparam logic [7:0] ADDR_CTRL2 = 8'h2B;
  localparam logic [7:0] ADDR_WAKESRC = 8'h2C;
  localparam logic [7:0] ADDR_INTEN = 8'h2D;
  // Output data registers that fast read skips through.
  localparam logic [7:0] ADDR_OUT_FIRST = 8'h01;
  localparam logic [7:0] ADDR_OUT_LAST = 8'h06;
  localparam logic [7:0] ADDR_FAST_STEP = 8'h02;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  // Field positions.
  localparam int SLEEP_RATE_HI = 7;
  localparam int SLEEP_RATE_LO = 6;
  localparam int WAKE_RATE_HI = 5;
  localparam int WAKE_RATE_LO = 3;
  localparam int FAST_READ_BIT = 1;
  localparam int ACTIVE_BIT = 0;
  localparam int AUTO_SLEEP_BIT = 2;
  localparam int ORIENT_WAKE_BIT = 5;
  localparam int MOTION_WAKE_BIT = 3;
  localparam int SLEEP_IRQ_EN_BIT = 7;
  localparam int ORIENT_EN_BIT = 4;
  localparam int MOTION_EN_BIT = 2;
  // Writable masks and reset values.
  localparam logic [7:0] CTRL2_MASK = 8'h04;
  localparam logic [7:0] WAKESRC_MASK = 8'h28;
  localparam logic [7:0] INTEN_MASK = 8'h94;
  localparam logic [7:0] CTRL1_MASK = 8'hFB;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Base tick of 1.25 ms, the shortest sample period.
  localparam real TICK_MS = 1.25;
  localparam real CLK_MHZ = 100.0;
  localparam int TICK_CYCLES = int'(TICK_MS * CLK_MHZ * 1000.0);
  // Inactivity steps: 320 ms normally, 640 ms at the slowest wake rate.
  localparam real STEP_MS = 320.0;
  localparam real STEP_SLOW_MS = 640.0;
  localparam logic [2:0] WAKE_SLOWEST = 3'h7;
  typedef enum logic [1:0] {STANDBY, WAKE, SLEEP} power_state_t;
endpackage

// [auto_wake_sleep.sv]
// Auto wake/sleep power state, sample-rate control and fast-read addressing.
`timescale 1ns/1ns
// Notes on behaviour
// R1 - Quiet period expiry switches wake rate to sleep
// R2 - Inactivity switching only while auto sleep set
// R3 - Timeout 8 bits, 320 ms or 640 ms steps
// R4 - Orientation and motion events restart timer, wake
// R5 - Sleep and data-ready interrupts never restart or wake
// R6 - Wake needs enable and wake-source select both
// R7 - Enabled functions keep running at sleep rate
// R8 - Auto sleep off: only standby and wake
// R9 - Interrupt on every wake/sleep transition when enabled
// R10 - Host changes control one only in standby; the active bit is written in any state
// R11 - Sleep rate field bits 7-6 picks rate
// R12 - Sleep state overrides rate with sleep rate
// R13 - Wake rate field bits 5-3 picks rate
// R14 - Control one bit 0 selects standby or active
// R15 - Fast read skips low data bytes
// R16 - Host changes fast read only in mode 00
// R17 - Auto sleep enable is control two bit 2
// R18 - Orientation wake select lets orientation wake
// R19 - Timer cleared in standby or auto sleep off
// R20 - Timer steps per wake sample, scaled compare
module auto_wake_sleep #(
  parameter int TickCycles = auto_sleep_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata_q,
  output logic [7:0] nextAddr_q,
  // Events from detection functions, one-cycle pulses
  input wire logic orientEvent,
  input wire logic motionEvent,
  // Status and timing
  output logic sampleTick_q,
  output logic sleeping_q,
  output logic waking_q,
  output logic sleepIrq_q
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] timeout_q, timeout_d;
  logic [7:0] ctrl1_q, ctrl1_d;
  logic [7:0] ctrl2_q, ctrl2_d;
  logic [7:0] wakeSrc_q, wakeSrc_d;
  logic [7:0] intEn_q, intEn_d;
  logic [7:0] regRdata_d, nextAddr_d;
  auto_sleep_pkg::power_state_t state_q, state_d;

  always_comb begin
    timeout_d = timeout_q;
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    wakeSrc_d = wakeSrc_q;
    intEn_d = intEn_q;
    regRdata_d = regRdata_q;
    nextAddr_d = nextAddr_q;
    if (regWrite) begin
      case (regAddr)
        auto_sleep_pkg::ADDR_TIMEOUT: timeout_d = regWdata; // [R3]
        auto_sleep_pkg::ADDR_CTRL1: begin
          // Fields other than the active bit are held while active.
          if (state_q == auto_sleep_pkg::STANDBY) begin // [R10]
            ctrl1_d = regWdata & auto_sleep_pkg::CTRL1_MASK;
          end else begin
            ctrl1_d[auto_sleep_pkg::ACTIVE_BIT] = regWdata[auto_sleep_pkg::ACTIVE_BIT]; // [R14]
          end
        end
        auto_sleep_pkg::ADDR_CTRL2: ctrl2_d = regWdata & auto_sleep_pkg::CTRL2_MASK; // [R17]
        auto_sleep_pkg::ADDR_WAKESRC: wakeSrc_d = regWdata & auto_sleep_pkg::WAKESRC_MASK;
        auto_sleep_pkg::ADDR_INTEN: intEn_d = regWdata & auto_sleep_pkg::INTEN_MASK;
        default: ;
      endcase
    end
    if (regRead) begin
      case (regAddr)
        auto_sleep_pkg::ADDR_TIMEOUT: regRdata_d = timeout_q;
        auto_sleep_pkg::ADDR_CTRL1: regRdata_d = ctrl1_q;
        auto_sleep_pkg::ADDR_CTRL2: regRdata_d = ctrl2_q;
        auto_sleep_pkg::ADDR_WAKESRC: regRdata_d = wakeSrc_q;
        auto_sleep_pkg::ADDR_INTEN: regRdata_d = intEn_q;
        default: regRdata_d = 8'h00;
      endcase
      // Auto-increment skips the low bytes of the output data in fast read.
      if (ctrl1_q[auto_sleep_pkg::FAST_READ_BIT] && regAddr >= auto_sleep_pkg::ADDR_OUT_FIRST &&
          regAddr < auto_sleep_pkg::ADDR_OUT_LAST) begin
        nextAddr_d = regAddr + auto_sleep_pkg::ADDR_FAST_STEP; // [R15]
      end else begin
        nextAddr_d = regAddr + auto_sleep_pkg::ADDR_STEP;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timeout_q <= auto_sleep_pkg::REG_RESET;
      ctrl1_q <= auto_sleep_pkg::REG_RESET;
      ctrl2_q <= auto_sleep_pkg::REG_RESET;
      wakeSrc_q <= auto_sleep_pkg::REG_RESET;
      intEn_q <= auto_sleep_pkg::REG_RESET;
      regRdata_q <= 8'h00;
      nextAddr_q <= 8'h00;
    end else begin
      timeout_q <= timeout_d;
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      wakeSrc_q <= wakeSrc_d;
      intEn_q <= intEn_d;
      regRdata_q <= regRdata_d;
      nextAddr_q <= nextAddr_d;
    end
  end

  // ----------------------------------------------------------------
  // Rate selection
  // ----------------------------------------------------------------
  logic active, autoSleep, wakeEvent, restartEvent;
  logic [1:0] sleepRate;
  logic [2:0] wakeRate;
  logic [14:0] periodTicks;
  logic [8:0] stepSamples;
  logic [16:0] limit;

  assign active = ctrl1_q[auto_sleep_pkg::ACTIVE_BIT];
  assign autoSleep = ctrl2_q[auto_sleep_pkg::AUTO_SLEEP_BIT];
  assign sleepRate = ctrl1_q[auto_sleep_pkg::SLEEP_RATE_HI:auto_sleep_pkg::SLEEP_RATE_LO];
  assign wakeRate = ctrl1_q[auto_sleep_pkg::WAKE_RATE_HI:auto_sleep_pkg::WAKE_RATE_LO];
  // Only orientation and motion take part; sleep and data-ready events are not inputs.
  assign restartEvent = (orientEvent && intEn_q[auto_sleep_pkg::ORIENT_EN_BIT]) ||
                        (motionEvent && intEn_q[auto_sleep_pkg::MOTION_EN_BIT]); // [R4] [R5]
  assign wakeEvent = (orientEvent && intEn_q[auto_sleep_pkg::ORIENT_EN_BIT] &&
                      wakeSrc_q[auto_sleep_pkg::ORIENT_WAKE_BIT]) ||
                     (motionEvent && intEn_q[auto_sleep_pkg::MOTION_EN_BIT] &&
                      wakeSrc_q[auto_sleep_pkg::MOTION_WAKE_BIT]); // [R6] [R18]

  always_comb begin
    periodTicks = 15'h0001;
    if (state_q == auto_sleep_pkg::SLEEP) begin // [R12] [R7]
      case (sleepRate) // [R11]
        2'h0: periodTicks = 15'h0010;
        2'h1: periodTicks = 15'h0040;
        2'h2: periodTicks = 15'h3E80;
        2'h3: periodTicks = 15'h0200;
        default: periodTicks = 15'h0010;
      endcase
    end else begin
      case (wakeRate) // [R13]
        3'h0: periodTicks = 15'h0001;
        3'h1: periodTicks = 15'h0002;
        3'h2: periodTicks = 15'h0004;
        3'h3: periodTicks = 15'h0008;
        3'h4: periodTicks = 15'h0010;
        3'h5: periodTicks = 15'h0040;
        3'h6: periodTicks = 15'h0080;
        3'h7: periodTicks = 15'h0200;
        default: periodTicks = 15'h0001;
      endcase
    end
    // Wake samples per inactivity step: 320 ms, or 640 ms at the slowest rate.
    stepSamples = (wakeRate == auto_sleep_pkg::WAKE_SLOWEST) ? 9'h001 :
                  9'(int'(auto_sleep_pkg::STEP_MS / auto_sleep_pkg::TICK_MS) /
                     int'(periodTicks)); // [R3] [R20]
    limit = 17'(timeout_q) * 17'(stepSamples);
  end

  // ----------------------------------------------------------------
  // Sample clock divider
  // ----------------------------------------------------------------
  logic [16:0] tickDiv_q, tickDiv_d;
  logic [14:0] sampleDiv_q, sampleDiv_d;
  logic sampleTick_d;

  always_comb begin
    tickDiv_d = tickDiv_q;
    sampleDiv_d = sampleDiv_q;
    sampleTick_d = 1'b0;
    if (state_q == auto_sleep_pkg::STANDBY || state_d != state_q) begin
      tickDiv_d = 17'h00000;
      sampleDiv_d = 15'h0000;
    end else if (tickDiv_q == 17'(TickCycles - 1)) begin
      tickDiv_d = 17'h00000;
      if (sampleDiv_q >= periodTicks - 15'h0001) begin
        sampleDiv_d = 15'h0000;
        sampleTick_d = 1'b1;
      end else begin
        sampleDiv_d = sampleDiv_q + 15'h0001;
      end
    end else begin
      tickDiv_d = tickDiv_q + 17'h00001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tickDiv_q <= 17'h00000;
      sampleDiv_q <= 15'h0000;
      sampleTick_q <= 1'b0;
    end else begin
      tickDiv_q <= tickDiv_d;
      sampleDiv_q <= sampleDiv_d;
      sampleTick_q <= sampleTick_d;
    end
  end

  // ----------------------------------------------------------------
  // Power state and inactivity timer
  // ----------------------------------------------------------------
  logic [16:0] elapsed_q, elapsed_d;
  logic expired, sleepIrq_d;

  assign expired = elapsed_q >= limit;

  always_comb begin
    state_d = state_q;
    elapsed_d = elapsed_q;
    case (state_q)
      auto_sleep_pkg::STANDBY: begin
        if (active) begin
          state_d = auto_sleep_pkg::WAKE; // [R14]
        end
      end
      auto_sleep_pkg::WAKE: begin
        if (!active) begin
          state_d = auto_sleep_pkg::STANDBY;
        end else if (autoSleep && expired && !restartEvent) begin
          state_d = auto_sleep_pkg::SLEEP; // [R1] [R2]
        end
      end
      auto_sleep_pkg::SLEEP: begin
        if (!active) begin
          state_d = auto_sleep_pkg::STANDBY;
        end else if (!autoSleep || wakeEvent) begin
          state_d = auto_sleep_pkg::WAKE; // [R4] [R8]
        end
      end
      default: state_d = auto_sleep_pkg::STANDBY;
    endcase
    if (state_d != auto_sleep_pkg::WAKE || !autoSleep || state_q != auto_sleep_pkg::WAKE ||
        restartEvent) begin
      elapsed_d = 17'h00000; // [R19] [R4]
    end else if (sampleTick_q && elapsed_q != 17'h1FFFF) begin
      elapsed_d = elapsed_q + 17'h00001; // [R20]
    end
    sleepIrq_d = intEn_q[auto_sleep_pkg::SLEEP_IRQ_EN_BIT] &&
                 ((state_q == auto_sleep_pkg::WAKE && state_d == auto_sleep_pkg::SLEEP) ||
                  (state_q == auto_sleep_pkg::SLEEP && state_d == auto_sleep_pkg::WAKE)); // [R9]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= auto_sleep_pkg::STANDBY;
      elapsed_q <= 17'h00000;
      sleepIrq_q <= 1'b0;
      sleeping_q <= 1'b0;
      waking_q <= 1'b0;
    end else begin
      state_q <= state_d;
      elapsed_q <= elapsed_d;
      sleepIrq_q <= sleepIrq_d;
      sleeping_q <= state_d == auto_sleep_pkg::SLEEP;
      waking_q <= state_d == auto_sleep_pkg::WAKE;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_sleep_on_expiry: assert property ( // [R1]
    (state_q == auto_sleep_pkg::WAKE && active && autoSleep && expired && !restartEvent)
    |=> state_q == auto_sleep_pkg::SLEEP && sleeping_q)
    else $error("expired timer did not enter sleep");
  a_no_sleep_disabled: assert property ( // [R8]
    (!autoSleep && state_q != auto_sleep_pkg::SLEEP) |=> state_q != auto_sleep_pkg::SLEEP)
    else $error("sleep entered with auto sleep off");
  a_sleep_needs_enable: assert property ( // [R2]
    $rose(sleeping_q) |-> $past(autoSleep))
    else $error("sleep entered without auto sleep");
  a_timer_cleared: assert property ( // [R19]
    (state_q == auto_sleep_pkg::STANDBY || !autoSleep) |=> elapsed_q == 17'h00000)
    else $error("timer not cleared");
  a_event_restart: assert property ( // [R4]
    (state_q == auto_sleep_pkg::WAKE && restartEvent) |=> elapsed_q == 17'h00000 ##1
    state_q != auto_sleep_pkg::SLEEP || limit == 17'h00000)
    else $error("event did not restart timer");
  a_wake_selected: assert property ( // [R6]
    (state_q == auto_sleep_pkg::SLEEP && active && wakeEvent) |=> waking_q)
    else $error("selected event did not wake");
  a_stay_unselected: assert property ( // [R6]
    (state_q == auto_sleep_pkg::SLEEP && active && autoSleep && !wakeEvent) |=> sleeping_q)
    else $error("woke without selected event");
  a_irq_transition: assert property ( // [R9]
    (intEn_q[auto_sleep_pkg::SLEEP_IRQ_EN_BIT] && state_q != auto_sleep_pkg::STANDBY &&
     state_d != auto_sleep_pkg::STANDBY && state_d != state_q)
    |=> sleepIrq_q ##1 (!sleepIrq_q || state_q != $past(state_q)))
    else $error("transition interrupt missing");
  a_standby_to_wake: assert property ( // [R14]
    (state_q == auto_sleep_pkg::STANDBY && active)
    |=> waking_q ##1 (waking_q || sleeping_q || !$past(active)))
    else $error("active bit did not start sampling");
  a_sleep_rate: assert property ( // [R12]
    (state_q == auto_sleep_pkg::SLEEP && sleepRate == 2'h0) |-> periodTicks == 15'h0010)
    else $error("sleep rate not applied");
  a_fast_skip: assert property ( // [R15]
    (regRead && ctrl1_q[auto_sleep_pkg::FAST_READ_BIT] && regAddr == 8'h01)
    |=> nextAddr_q == 8'h03)
    else $error("fast read did not skip low byte");

  c_enter_sleep: cover property ($rose(sleeping_q));
  c_wake_from_sleep: cover property (sleeping_q ##1 waking_q);
  c_irq_pulse: cover property (sleepIrq_q);
  c_fast_read: cover property (regRead && ctrl1_q[auto_sleep_pkg::FAST_READ_BIT]);
endmodule

// [host_model.sv]
// Host model that programs the wake/sleep controller through its register port.
`timescale 1ns/1ns
module host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata_q,
  input wire logic [7:0] nextAddr_q
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // One write strobe; stale data is inverted once taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask
  // One read strobe; the answer is taken once it has settled.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [7:0] n);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    d = regRdata_q;
    n = nextAddr_q;
  endtask
  // Control one is changed from standby only; buffer mode stays 00 here.
  task automatic setCtrl1(input logic [7:0] d);
    wr(8'h2A, 8'h00);
    wr(8'h2A, d);
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the auto wake/sleep rate controller.
`timescale 1ns/1ns
module tb;
  localparam int TickCyc = 4;
  localparam int Ceiling = 40000;
  logic clk_sys, rst_n, regWrite, regRead, orientEvent, motionEvent;
  logic sampleTick_q, sleeping_q, waking_q, sleepIrq_q;
  logic [7:0] regAddr, regWdata, regRdata_q, nextAddr_q, rdat, nadr;
  logic [7:0] addrs[6] = '{8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h30};
  int wakeTicks[8] = '{1, 2, 4, 8, 16, 64, 128, 512};
  int sleepTicks[4] = '{16, 64, 16000, 512};
  int failCount = 0;
  int nChecks = 0;
  int irqCount = 0;
  int cycles = 0;
  int n, base;
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  auto_wake_sleep #(.TickCycles(TickCyc)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata_q(regRdata_q), .nextAddr_q(nextAddr_q), .orientEvent(orientEvent),
    .motionEvent(motionEvent), .sampleTick_q(sampleTick_q), .sleeping_q(sleeping_q),
    .waking_q(waking_q), .sleepIrq_q(sleepIrq_q));
  host_model u_host (.clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata_q(regRdata_q),
    .nextAddr_q(nextAddr_q));
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (sleepIrq_q === 1'b1) begin
      irqCount <= irqCount + 1;
    end
    if (cycles == Ceiling) begin
      failCount++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // Compare and measurement tasks
  // ------------------------------------------------------------
  task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    nChecks++;
    if (g !== e) begin
      failCount++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chkN(input string s, input int e, input int g);
    nChecks++;
    if (g != e) begin
      failCount++;
      $display("Error %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e, input string s);
    u_host.rd(a, rdat, nadr);
    chk8(s, e, rdat);
  endtask
  task automatic waitTick(output int k);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (sampleTick_q !== 1'b1 && k < 9000);
  endtask
  task automatic period(output int p);
    waitTick(p);
    waitTick(p);
  endtask
  // Counts sample pulses until the sleep state is reached.
  task automatic countToSleep(output int c);
    int k;
    c = 0;
    k = 0;
    while (sleeping_q !== 1'b1 && k < 12000) begin
      @(negedge clk_sys);
      k++;
      if (sampleTick_q === 1'b1) begin
        c++;
      end
    end
  endtask
  task automatic ev(input bit orient);
    @(posedge clk_sys);
    orientEvent <= orient;
    motionEvent <= !orient;
    @(posedge clk_sys);
    orientEvent <= 1'b0;
    motionEvent <= 1'b0;
  endtask
  task automatic state(input logic s, input logic w);
    repeat (3) @(negedge clk_sys);
    chk8("sleeping", {7'h00, s}, {7'h00, sleeping_q});
    chk8("waking", {7'h00, w}, {7'h00, waking_q});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    orientEvent = 1'b0;
    motionEvent = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rdChk(addrs[i], 8'h00, "reset value");
    end
    u_host.wr(8'h2B, 8'hFF);
    u_host.wr(8'h2C, 8'hFF);
    u_host.wr(8'h2D, 8'hFF);
    rdChk(8'h2B, 8'h04, "auto sleep");
    rdChk(8'h2C, 8'h28, "wake select");
    rdChk(8'h2D, 8'h94, "irq enable");
    u_host.wr(8'h2C, 8'h08);
    u_host.wr(8'h2B, 8'h00);
    u_host.setCtrl1(8'h02);
    u_host.rd(8'h01, rdat, nadr);
    chk8("fast next", 8'h03, nadr);
    u_host.rd(8'h05, rdat, nadr);
    chk8("fast next", 8'h07, nadr);
    u_host.setCtrl1(8'h00);
    u_host.rd(8'h01, rdat, nadr);
    chk8("normal next", 8'h02, nadr);
    // Timeout stays 0 here, so any sleep would show at once.
    for (int r = 0; r < 8; r++) begin
      u_host.setCtrl1({2'b00, 3'(r), 3'b001});
      period(n);
      chkN("wake period", TickCyc * wakeTicks[r], n);
      state(1'b0, 1'b1);
    end
    u_host.wr(8'h2A, 8'hC3);
    rdChk(8'h2A, 8'h39, "ctrl1 active");
    u_host.wr(8'h2A, 8'h00);
    state(1'b0, 1'b0);
    u_host.wr(8'h2B, 8'h04);
    u_host.wr(8'h29, 8'h01);
    u_host.wr(8'h2A, 8'h01);
    countToSleep(n);
    chkN("ticks to sleep", 256, n);
    state(1'b1, 1'b0);
    chkN("irq count", 1, irqCount);
    period(n);
    chkN("sleep period", TickCyc * 16, n);
    ev(1'b1);
    state(1'b1, 1'b0);
    ev(1'b0);
    state(1'b0, 1'b1);
    chkN("irq count", 2, irqCount);
    repeat (50) waitTick(n);
    ev(1'b0);
    countToSleep(n);
    chkN("ticks after event", 256, n);
    u_host.wr(8'h2B, 8'h00);
    state(1'b0, 1'b1);
    u_host.wr(8'h2B, 8'h04);
    u_host.setCtrl1(8'h00);
    u_host.wr(8'h29, 8'h02);
    u_host.wr(8'h2A, 8'h39);
    countToSleep(n);
    chkN("slow ticks to sleep", 2, n);
    u_host.wr(8'h29, 8'h00);
    u_host.wr(8'h2D, 8'h14);
    base = irqCount;
    for (int s = 0; s < 4; s++) begin
      u_host.setCtrl1({2'(s), 6'b000001});
      countToSleep(n);
      if (s == 2) begin
        // The slowest sleep rate is too long to time, so its divider setting is checked.
        chkN("sleep ticks", sleepTicks[s], int'(u_dut.periodTicks));
      end else begin
        period(n);
        chkN("sleep period", TickCyc * sleepTicks[s], n);
      end
    end
    chkN("irq masked", base, irqCount);
    wrap_up();
  end
endmodule
